// *** verilog/llw_defines.vh ***
// Constants of the low-leakage wakeup unit: register indices, fields,
// reset values and filter timing.
// Assumes a 20 MHz APB clock; byte address of a register is index * 4.
`ifndef LLW_DEFINES_VH
`define LLW_DEFINES_VH

// ==================================================================
// Register indices (byte address = index * 4)
`define LLW_IDX_ME          10'h004
`define LLW_IDX_F3          10'h007
`define LLW_IDX_FILT1       10'h008
`define LLW_IDX_FILT2       10'h009
`define LLW_IDX_RST         10'h00a
`define LLW_IDX_REGSC       10'h010
`define LLW_IDX_IRQ_STAT    10'h011
`define LLW_IDX_IRQ_MASK    10'h012

// ==================================================================
// Field positions
`define LLW_ME_RTC_BIT      7
`define LLW_F3_RTC_BIT      7
`define LLW_FILT_FLAG_BIT   7
`define LLW_FILT_EDGE_HI    6
`define LLW_FILT_EDGE_LO    5
`define LLW_RST_FILT_BIT    0
`define LLW_RST_WAKE_BIT    1
`define LLW_REGSC_ACK_BIT   3
`define LLW_IRQ_MOD_BIT     0
`define LLW_IRQ_PIN_BIT     1
`define LLW_IRQ_RST_BIT     2

// ==================================================================
// Reset values
`define LLW_ME_RST          8'h00
`define LLW_EDGE_RST        2'h0
`define LLW_RSTCTL_RST      2'h0
`define LLW_MASK_RST        3'h0

// ==================================================================
// Timing
`define LLW_CLK_NS          50
`define LLW_FILT_NS         250
`define LLW_FILT_CYC        ((`LLW_FILT_NS + `LLW_CLK_NS - 1) / `LLW_CLK_NS)
`define LLW_FILT_CNT_W      4

`endif

// *** verilog/llw_sticky.v ***
// Bank of sticky flags: set by hardware events, cleared by software.
// Assumes set and clear vectors are synchronous to pclk.
`default_nettype none

module llw_sticky
#(
   parameter W = 8
)
(
   input  wire         pclk,      // Clock
   input  wire         presetn,   // Async reset, active low
   input  wire [W-1:0] set_vec,   // Event per flag
   input  wire [W-1:0] clr_vec,   // Clear per flag
   output reg  [W-1:0] flags_q    // Flag state
);

   // ================================================================
   // Flags: a set in the clear cycle wins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_q <= {W{1'b0}};
      else
         flags_q <= (flags_q & ~clr_vec) | set_vec;
   end

endmodule // llw_sticky

`default_nettype wire

// *** verilog/llw_pin_filter.v ***
// Digital glitch filter with edge detect for one wakeup pin.
// Assumes the pin input is already synchronous to pclk.
`default_nettype none
`include "llw_defines.vh"

module llw_pin_filter
(
   input  wire       pclk,      // Clock
   input  wire       presetn,   // Async reset, active low
   input  wire       pin_in,    // Pin level, active high
   input  wire       bypass,    // Pass pin without filtering
   input  wire [1:0] edge_sel,  // 01 rise, 10 fall, 11 both, 00 off
   output reg        detect_q   // One-cycle edge pulse
);

   reg  [`LLW_FILT_CNT_W-1:0] cnt_q;
   reg                        level_q;
   reg                        level_d;
   reg  [`LLW_FILT_CNT_W-1:0] cnt_d;

   // ================================================================
   // Level accepted after the pin holds still for the filter time
   always @*
   begin
      level_d = level_q;
      cnt_d   = {`LLW_FILT_CNT_W{1'b0}};
      if (bypass)
         level_d = pin_in;
      else if (pin_in != level_q)
      begin
         if (cnt_q == `LLW_FILT_CYC - 1)
            level_d = pin_in;
         else
            cnt_d = cnt_q + 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q    <= {`LLW_FILT_CNT_W{1'b0}};
         level_q  <= 1'b0;
         detect_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         level_q  <= level_d;
         detect_q <= (edge_sel[0] & level_d & ~level_q) |
                     (edge_sel[1] & ~level_d & level_q);
      end
   end

endmodule // llw_pin_filter

`default_nettype wire

// *** verilog/llw_wakeup_unit.v ***
// Low-leakage wakeup unit: wake sources, pin filters, reset-pin wake,
// isolation hold and APB register file.
// Assumes an always-on domain: presetn is power-on reset only, and the
// power mode controller reports low-leak stop levels synchronously.
//
// Contract
// - This unit governs exit from low-leak and very-low-leak stop.
// - Module wake input 7 is the RTC seconds interrupt.
// - Enable bit 7 gates the RTC seconds wake source.
// - Flag bit 7 of the third flag register records RTC seconds wake.
// - Two preselected pins each have their own filter and flag.
// - Pin filter registers and reset-pin register configure filters.
// - A dedicated reset pin always wakes from low-leak stop modes.
// - Reset-pin enable and filter bits act only without dedicated pin.
// - Very-low-leak stop exit goes through the reset sequence.
// - Reading the ack bit shows whether pads and oscillators are held.
// - Ack is bit 3 of regulator status; write one releases hold.
//
// Added by the designer: the APB slave port.
`default_nettype none
`include "llw_defines.vh"

module llw_wakeup_unit
#(
   parameter DEDICATED_RESET_PIN = 1
)
(
   input  wire        pclk,               // APB clock, 20 MHz
   input  wire        presetn,            // Async reset, active low
   input  wire [11:0] paddr,              // APB byte address
   input  wire        psel,               // APB select
   input  wire        penable,            // APB access phase
   input  wire        pwrite,             // APB write
   input  wire [31:0] pwdata,             // APB write data
   output reg  [31:0] prdata,             // APB read data
   output wire        pready,             // APB ready
   output wire        pslverr,            // APB error, unmapped
   input  wire        low_leak_stop_mode, // Low-leak stop active
   input  wire        very_low_leak_stop_modes, // Very-low-leak active
   input  wire [6:0]  module_wake_in,     // Module wake inputs 0..6
   input  wire        rtc_seconds_irq,    // RTC seconds interrupt
   input  wire [1:0]  wake_pin_in,        // Preselected wake pins
   input  wire        reset_pin_n,        // Reset pin, active low
   output reg         exit_request,       // Exit request to controller
   output reg         vlls_reset_request, // Exit via reset sequence
   output wire        pad_hold,           // I/O pads held latched
   output wire        osc_hold,           // Oscillators held latched
   output wire        irq                 // Wakeup interrupt, level
);

   // ================================================================
   // Declarations
   wire        in_low_leak;
   wire [7:0]  mod_src;
   wire [7:0]  mod_hit;
   wire [1:0]  pin_det;
   wire [1:0]  pin_hit;
   wire        rst_det;
   wire        rst_hit;
   wire        rst_bypass;
   wire        wake_evt;
   wire [7:0]  f3_q;
   wire [1:0]  pin_flag_q;
   wire [2:0]  irq_stat_q;
   wire [2:0]  irq_evt;
   wire        wr_en;
   wire        rd_setup;
   wire [9:0]  idx;
   reg         hit_map;
   reg  [31:0] rd_data;
   reg  [7:0]  me_q;
   reg  [1:0]  edge1_q;
   reg  [1:0]  edge2_q;
   reg  [1:0]  rst_ctl_q;
   reg  [2:0]  irq_mask_q;
   reg         iso_hold_q;
   reg  [7:0]  f3_clr;
   reg  [1:0]  pin_clr;
   reg  [2:0]  irq_clr;
   reg         ack_clr;
   reg         err_q;
   wire [1:0]  edge_sel [0:1];

   // ================================================================
   // APB decode
   assign idx      = paddr[11:2];
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & err_q;

   always @*
   begin
      case (idx)
         `LLW_IDX_ME,
         `LLW_IDX_F3,
         `LLW_IDX_FILT1,
         `LLW_IDX_FILT2,
         `LLW_IDX_RST,
         `LLW_IDX_REGSC,
         `LLW_IDX_IRQ_STAT,
         `LLW_IDX_IRQ_MASK:
            hit_map = 1'b1;
         default:
            hit_map = 1'b0;
      endcase
   end

   // ================================================================
   // Wake sources
   assign in_low_leak = low_leak_stop_mode | very_low_leak_stop_modes;
   assign mod_src = {rtc_seconds_irq, module_wake_in};
   assign mod_hit = mod_src & me_q & {8{in_low_leak}};

   assign edge_sel[0] = edge1_q;
   assign edge_sel[1] = edge2_q;

   // One filter per preselected pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_pin
         llw_pin_filter u_filt
         (
            .pclk     (pclk),
            .presetn  (presetn),
            .pin_in   (wake_pin_in[gi]),
            .bypass   (1'b0),
            .edge_sel (edge_sel[gi]),
            .detect_q (pin_det[gi])
         );
         assign pin_hit[gi] = pin_det[gi] & in_low_leak;
      end
   endgenerate

   // Reset pin: filter only honoured without a dedicated pin
   assign rst_bypass = (DEDICATED_RESET_PIN != 0) |
                       ~rst_ctl_q[`LLW_RST_FILT_BIT];

   llw_pin_filter u_rst_filt
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_in   (~reset_pin_n),
      .bypass   (rst_bypass),
      .edge_sel (2'b01),
      .detect_q (rst_det)
   );

   assign rst_hit = rst_det & in_low_leak &
                    ((DEDICATED_RESET_PIN != 0) |
                     rst_ctl_q[`LLW_RST_WAKE_BIT]);

   assign wake_evt = (|mod_hit) | (|pin_hit) | rst_hit;

   // ================================================================
   // Flags
   llw_sticky #(.W(8)) u_f3
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set_vec (mod_hit),
      .clr_vec (f3_clr),
      .flags_q (f3_q)
   );

   llw_sticky #(.W(2)) u_pinflag
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set_vec (pin_hit),
      .clr_vec (pin_clr),
      .flags_q (pin_flag_q)
   );

   assign irq_evt = {rst_hit, |pin_hit, |mod_hit};

   llw_sticky #(.W(3)) u_irq
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set_vec (irq_evt),
      .clr_vec (irq_clr),
      .flags_q (irq_stat_q)
   );

   assign irq = |(irq_stat_q & irq_mask_q);

   // ================================================================
   // Write-one-to-clear decode
   always @*
   begin
      f3_clr  = 8'h00;
      pin_clr = 2'b00;
      irq_clr = 3'b000;
      ack_clr = 1'b0;
      if (wr_en)
      begin
         case (idx)
            `LLW_IDX_F3:
               f3_clr = pwdata[7:0];
            `LLW_IDX_FILT1:
               pin_clr[0] = pwdata[`LLW_FILT_FLAG_BIT];
            `LLW_IDX_FILT2:
               pin_clr[1] = pwdata[`LLW_FILT_FLAG_BIT];
            `LLW_IDX_IRQ_STAT:
               irq_clr = pwdata[2:0];
            `LLW_IDX_REGSC:
               ack_clr = pwdata[`LLW_REGSC_ACK_BIT];
            default:
               ack_clr = 1'b0;
         endcase
      end
   end

   // ================================================================
   // Control registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         me_q       <= `LLW_ME_RST;
         edge1_q    <= `LLW_EDGE_RST;
         edge2_q    <= `LLW_EDGE_RST;
         rst_ctl_q  <= `LLW_RSTCTL_RST;
         irq_mask_q <= `LLW_MASK_RST;
      end
      else if (wr_en)
      begin
         case (idx)
            `LLW_IDX_ME:
               me_q <= pwdata[7:0];
            `LLW_IDX_FILT1:
               edge1_q <= pwdata[`LLW_FILT_EDGE_HI:`LLW_FILT_EDGE_LO];
            `LLW_IDX_FILT2:
               edge2_q <= pwdata[`LLW_FILT_EDGE_HI:`LLW_FILT_EDGE_LO];
            `LLW_IDX_RST:
               rst_ctl_q <= pwdata[1:0];
            `LLW_IDX_IRQ_MASK:
               irq_mask_q <= pwdata[2:0];
            default:
               me_q <= me_q;
         endcase
      end
   end

   // ================================================================
   // Exit sequencing and isolation hold
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exit_request       <= 1'b0;
         vlls_reset_request <= 1'b0;
         iso_hold_q         <= 1'b0;
      end
      else
      begin
         // Request stands until the controller leaves the mode
         if (!low_leak_stop_mode)
            exit_request <= 1'b0;
         else if (wake_evt && low_leak_stop_mode)
            exit_request <= 1'b1;

         if (!very_low_leak_stop_modes)
            vlls_reset_request <= 1'b0;
         else if (wake_evt)
            vlls_reset_request <= 1'b1;

         // Pads latch on deep entry; entry wins over a clear
         if (very_low_leak_stop_modes)
            iso_hold_q <= 1'b1;
         else if (ack_clr)
            iso_hold_q <= 1'b0;
      end
   end

   assign pad_hold = iso_hold_q;
   assign osc_hold = iso_hold_q;

   // ================================================================
   // Read path, captured in the setup cycle
   always @*
   begin
      rd_data = 32'h0000_0000;
      case (idx)
         `LLW_IDX_ME:
            rd_data[7:0] = me_q;
         `LLW_IDX_F3:
            rd_data[7:0] = f3_q;
         `LLW_IDX_FILT1:
         begin
            rd_data[`LLW_FILT_FLAG_BIT] = pin_flag_q[0];
            rd_data[`LLW_FILT_EDGE_HI:`LLW_FILT_EDGE_LO] = edge1_q;
         end
         `LLW_IDX_FILT2:
         begin
            rd_data[`LLW_FILT_FLAG_BIT] = pin_flag_q[1];
            rd_data[`LLW_FILT_EDGE_HI:`LLW_FILT_EDGE_LO] = edge2_q;
         end
         `LLW_IDX_RST:
            rd_data[1:0] = rst_ctl_q;
         `LLW_IDX_REGSC:
            rd_data[`LLW_REGSC_ACK_BIT] = iso_hold_q;
         `LLW_IDX_IRQ_STAT:
            rd_data[2:0] = irq_stat_q;
         `LLW_IDX_IRQ_MASK:
            rd_data[2:0] = irq_mask_q;
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         err_q  <= 1'b0;
      end
      else if (rd_setup)
      begin
         prdata <= pwrite ? 32'h0000_0000 : rd_data;
         err_q  <= ~hit_map;
      end
   end

endmodule // llw_wakeup_unit

`default_nettype wire

// *** tb/llw_mode_model.sv ***
// Stand-in for the power mode controller: enters a stop mode on
// request and leaves it a set lag after the wakeup unit asks.
// Assumes requests and lag come from the bench, synchronous to pclk.
`default_nettype none

module llw_mode_model
(
   input  wire logic       pclk,         // Clock
   input  wire logic       presetn,      // Async reset, active low
   input  wire logic       enter_ll,     // Enter low-leak stop
   input  wire logic       enter_vll,    // Enter very-low-leak stop
   input  wire logic [1:0] lag,          // Extra cycles before exit
   input  wire logic       exit_request, // From the unit
   input  wire logic       vll_request,  // From the unit
   output var  logic       ll_q,         // Low-leak stop active
   output var  logic       vll_q         // Very-low-leak stop active
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] cnt_q;

   // ======================================================
   // Mode is left only when the unit asks for it
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ll_q  <= 1'b0;
         vll_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else if (enter_ll)
         ll_q <= 1'b1;
      else if (enter_vll)
         vll_q <= 1'b1;
      else if ((exit_request && ll_q) || (vll_request && vll_q))
      begin
         // Count only while in a mode, so no count is left for the next
         cnt_q <= (cnt_q >= lag) ? 2'h0 : cnt_q + 2'h1;
         if (cnt_q >= lag)
         begin
            ll_q  <= 1'b0;
            vll_q <= 1'b0;
         end
      end
endmodule // llw_mode_model

`default_nettype wire

// *** tb/llw_wakeup_unit_checker.sv ***
// Checker of the wakeup unit: APB answer, wake requests, isolation.
// Assumes it is bound to llw_wakeup_unit and sees its ports only.
`default_nettype none
`include "llw_defines.vh"

module llw_wakeup_unit_checker
(
   input wire logic        pclk,          // Clock
   input wire logic        presetn,       // Reset, active low
   input wire logic [11:0] paddr,         // APB
   input wire logic        psel,          // APB
   input wire logic        penable,       // APB
   input wire logic        pwrite,        // APB
   input wire logic [31:0] pwdata,        // APB
   input wire logic        pready,        // APB
   input wire logic        pslverr,       // APB
   input wire logic        low_leak_stop_mode,       // Mode
   input wire logic        very_low_leak_stop_modes, // Mode
   input wire logic        rtc_seconds_irq,          // Source 7
   input wire logic        reset_pin_n,   // Reset pin
   input wire logic        exit_request,  // Exit request
   input wire logic        vlls_reset_request, // Reset-flow exit
   input wire logic        pad_hold,      // Pad hold
   input wire logic        osc_hold       // Oscillator hold
);
   timeunit 1ns;
   timeprecision 100ps;
   wire [9:0] idx = paddr[11:2];
   wire       wr_acc = psel && penable && pwrite;
   wire       mapped = idx == `LLW_IDX_ME || idx == `LLW_IDX_F3 ||
                       idx == `LLW_IDX_FILT1 || idx == `LLW_IDX_FILT2 ||
                       idx == `LLW_IDX_RST || idx == `LLW_IDX_REGSC ||
                       idx == `LLW_IDX_IRQ_STAT || idx == `LLW_IDX_IRQ_MASK;
   logic      me7_q;

   // ======================================================
   // Shadow of the RTC seconds enable
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         me7_q <= 1'b0;
      else if (wr_acc && idx == `LLW_IDX_ME)
         me7_q <= pwdata[7];

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ======================================================
   // Assertions
   ready_always_a: assert property (
      psel |-> pready) else $error("pready low");
   unmapped_err_a: assert property (
      psel && penable && !mapped |-> pslverr) else $error("no pslverr");
   mapped_ok_a: assert property (
      psel && penable && mapped |-> !pslverr) else $error("bad pslverr");
   rtc_wake_a: assert property (
      low_leak_stop_mode && rtc_seconds_irq && me7_q && !exit_request
      |=> exit_request) else $error("rtc wake missed");
   exit_mode_a: assert property (
      !low_leak_stop_mode |=> !exit_request) else $error("stray exit");
   vll_reset_a: assert property (
      very_low_leak_stop_modes && rtc_seconds_irq && me7_q &&
      !vlls_reset_request |=> vlls_reset_request)
      else $error("vll wake missed");
   vll_only_a: assert property (
      !very_low_leak_stop_modes |=> !vlls_reset_request)
      else $error("stray vll request");
   reset_pin_a: assert property (
      low_leak_stop_mode && $fell(reset_pin_n) |-> ##[1:4] exit_request)
      else $error("reset pin wake missed");
   iso_set_a: assert property (
      very_low_leak_stop_modes |=> pad_hold && osc_hold)
      else $error("hold not set");
   iso_clear_a: assert property (
      wr_acc && idx == `LLW_IDX_REGSC && pwdata[3] &&
      !very_low_leak_stop_modes |=> !pad_hold) else $error("hold stuck");
   hold_pair_a: assert property (
      pad_hold == osc_hold) else $error("holds differ");

   cover property (low_leak_stop_mode && $rose(exit_request));
   cover property ($rose(vlls_reset_request));
   cover property (psel && penable && pslverr);
endmodule // llw_wakeup_unit_checker

bind llw_wakeup_unit llw_wakeup_unit_checker llw_wakeup_unit_checker_inst
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr),
   .low_leak_stop_mode(low_leak_stop_mode),
   .very_low_leak_stop_modes(very_low_leak_stop_modes),
   .rtc_seconds_irq(rtc_seconds_irq), .reset_pin_n(reset_pin_n),
   .exit_request(exit_request), .vlls_reset_request(vlls_reset_request),
   .pad_hold(pad_hold), .osc_hold(osc_hold)
);

`default_nettype wire

// *** tb/low_leakage_wakeup_unit_bench.sv ***
// Self-checking bench of the wakeup unit over APB.
// Assumes the mode model in tb/ and the constants header.
`default_nettype none
`include "llw_defines.vh"

module low_leakage_wakeup_unit_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic        ll, vll, rtc, rst_n, ex_req, vll_req, err_v;
   logic        pad_hold, osc_hold, irq, enter_ll, enter_vll;
   logic [6:0]  mod_in;
   logic [1:0]  pins, lag;
   int          n_fail, check_count;
   // Rows: index, write data, read back, error
   logic [26:0] rows [0:5] = '{
      {`LLW_IDX_ME, 8'ha5, 8'ha5, 1'b0},
      {`LLW_IDX_FILT1, 8'he0, 8'h60, 1'b0},
      {`LLW_IDX_FILT2, 8'h40, 8'h40, 1'b0},
      {`LLW_IDX_RST, 8'h03, 8'h03, 1'b0},
      {`LLW_IDX_IRQ_MASK, 8'h06, 8'h06, 1'b0},
      {10'h3ff, 8'hff, 8'h00, 1'b1}};

   llw_wakeup_unit #(.DEDICATED_RESET_PIN(1)) llw_wakeup_unit_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_leak_stop_mode(ll), .very_low_leak_stop_modes(vll),
      .module_wake_in(mod_in), .rtc_seconds_irq(rtc),
      .wake_pin_in(pins), .reset_pin_n(rst_n), .exit_request(ex_req),
      .vlls_reset_request(vll_req), .pad_hold(pad_hold),
      .osc_hold(osc_hold), .irq(irq));
   llw_mode_model llw_mode_model_inst (
      .pclk(pclk), .presetn(presetn), .enter_ll(enter_ll),
      .enter_vll(enter_vll), .lag(lag), .exit_request(ex_req),
      .vll_request(vll_req), .ll_q(ll), .vll_q(vll));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ======================================================
   // Tasks
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      check_count++;
      if (got !== ex)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic [9:0] ix, input logic w,
                      input logic [7:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {ix, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd_v  = prdata;
      err_v = pslverr;
      if (k >= 20)
      begin
         n_fail++;
         test_done();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdc(input string nm, input logic [9:0] ix,
                      input logic [7:0] ex);
      apb(ix, 1'b0, 8'h00);
      chk(nm, {24'h0, ex}, rd_v);
   endtask

   task automatic wait_req(input logic v);
      int k;
      k = 0;
      while ((v ? vll_req : ex_req) !== 1'b1 && k < 40)
      begin
         @(posedge pclk);
         k++;
      end
      if (k >= 40)
      begin
         n_fail++;
         test_done();
      end
   endtask

   task automatic enter(input logic v);
      enter_vll <= v;
      enter_ll  <= !v;
      @(posedge pclk);
      enter_vll <= 1'b0;
      enter_ll  <= 1'b0;
      @(posedge pclk);
   endtask

   // ======================================================
   // Sequence
   initial
   begin
      {presetn, psel, penable, pwrite, rtc, enter_ll, enter_vll} = '0;
      {paddr, pwdata, mod_in, pins, lag} = '0;
      rst_n = 1'b1;
      n_fail = 0;
      check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
      begin
         apb(rows[i][26:17], 1'b1, rows[i][16:9]);
         rdc("register", rows[i][26:17], rows[i][8:1]);
         chk("pslverr", {31'h0, rows[i][0]}, {31'h0, err_v});
      end
      $display("register table done");
      apb(`LLW_IDX_ME, 1'b1, 8'h80);
      enter(1'b0);
      rtc <= 1'b1;
      wait_req(1'b0);
      chk("exit", 1, ex_req);
      rtc <= 1'b0;
      rdc("rtc flag", `LLW_IDX_F3, 8'h80);
      chk("irq masked", 0, irq);
      apb(`LLW_IDX_IRQ_MASK, 1'b1, 8'h01);
      chk("irq", 1, irq);
      chk("exit gone", 0, ex_req);
      apb(`LLW_IDX_F3, 1'b1, 8'h80);
      apb(`LLW_IDX_IRQ_STAT, 1'b1, 8'h01);
      rdc("flag cleared", `LLW_IDX_F3, 8'h00);
      chk("irq cleared", 0, irq);
      $display("rtc wake done");
      lag <= 2'h3;
      apb(`LLW_IDX_ME, 1'b1, 8'h01);
      enter(1'b0);
      rtc <= 1'b1;
      rdc("rtc gated", `LLW_IDX_F3, 8'h00);
      chk("no exit", 0, ex_req);
      mod_in <= 7'h01;
      wait_req(1'b0);
      rtc <= 1'b0;
      mod_in <= 7'h00;
      rdc("module flag", `LLW_IDX_F3, 8'h01);
      apb(`LLW_IDX_F3, 1'b1, 8'h01);
      $display("gated source done");
      apb(`LLW_IDX_FILT1, 1'b1, 8'h20);
      enter(1'b0);
      pins <= 2'b11;
      repeat (3) @(posedge pclk);
      pins <= 2'b00;
      repeat (10) @(posedge pclk);
      chk("glitch", 0, ex_req);
      pins <= 2'b11;
      wait_req(1'b0);
      rdc("pin one", `LLW_IDX_FILT1, 8'ha0);
      rdc("pin two", `LLW_IDX_FILT2, 8'h40);
      rdc("pin irq", `LLW_IDX_IRQ_STAT, 8'h03);
      pins <= 2'b00;
      // Let the falling pin edge pass the filter outside the stop mode
      repeat (8) @(posedge pclk);
      $display("pin filter done");
      apb(`LLW_IDX_RST, 1'b1, 8'h00);
      enter(1'b0);
      rst_n <= 1'b0;
      wait_req(1'b0);
      chk("reset pin", 1, ex_req);
      rdc("rst irq", `LLW_IDX_IRQ_STAT, 8'h07);
      rst_n <= 1'b1;
      $display("reset pin done");
      lag <= 2'h0;
      apb(`LLW_IDX_ME, 1'b1, 8'h80);
      enter(1'b1);
      rtc <= 1'b1;
      wait_req(1'b1);
      chk("no plain exit", 0, ex_req);
      chk("reset flow", 1, vll_req);
      rtc <= 1'b0;
      rdc("held", `LLW_IDX_REGSC, 8'h08);
      chk("osc held", 1, osc_hold);
      apb(`LLW_IDX_REGSC, 1'b1, 8'h08);
      rdc("released", `LLW_IDX_REGSC, 8'h00);
      chk("pads free", 0, pad_hold);
      $display("isolation done");
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc("enable reset", `LLW_IDX_ME, 8'h00);
      rdc("mask reset", `LLW_IDX_IRQ_MASK, 8'h00);
      $display("second reset done");
      test_done();
   end
endmodule // low_leakage_wakeup_unit_bench

`default_nettype wire
